// *** core/pst_translator.v ***
// privilege mode segment translator top
// Operation
// - user mode: user bit set, exception and error bits clear, not debug
// - kernel mode: not debug and user bit clear or exception or error set
// - user access with address bit 31 set raises address error
// - kernel mode picks region from address top bits
// - region A unmapped, minus 0x80000000, low kernel cache attribute
// - region B unmapped, minus 0xA0000000, uncached
// - regions C and D translate identically
// - error level set makes user region unmapped, uncached, identity
// - mapped regions use high kernel and user attributes; no write protection
// - core uncached internally, attribute still forwarded to system
// - reset and any exception except debug exception enter kernel mode
// - exception sets level bits; return clears error, exception if error clear
// - debug exception enters debug mode with overlay in region D
// - overlay switchable in debug mode; off gives plain region D
// - probe window maps to probe offsets, always uncached
// - register window maps onto debug registers
// - register window: normal-memory load/store to D, else debug registers
// - probe window: normal-memory load/store to D, else probe, present bit or not
// - probe window reference without probe present stalls until probe answers
// - writes to unimplemented debug registers ignored
// - debug register window accepts word transactions only
// - in debug mode kernel-faulting access raises debug exception instead
// - cache fields at config bits 30:28, 27:25, 2:0
// - error level bit set after reset, soft reset or nmi
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.vh"
module pst_translator
(
	input wire CLK_I,
	input wire RST_I,
	input wire USER_PRIVILEGE_BIT_I,
	input wire EXC_I,
	input wire ERR_EXC_I,
	input wire EXCEPTION_RETURN_OP_I,
	input wire [31:0] EXCEPTION_RETURN_PC_I,
	input wire NMI_I,
	input wire SOFT_RESET_I,
	input wire DEBUG_EXC_I,
	input wire DEBUG_RETURN_I,
	input wire [31:0] CONFIG_I,
	input wire LOAD_STORE_NORMAL_MEMORY_BIT_I,
	input wire PROBE_PRESENT_BIT_I,
	input wire OVERLAY_ENABLE_I,
	input wire REQ_VALID_I,
	input wire REQ_FETCH_I,
	input wire REQ_WRITE_I,
	input wire [1:0] REQ_SIZE_I,
	input wire [31:0] REQ_VADDR_I,
	input wire DREG_IMPL_I,
	input wire PROBE_ACK_I,
	output wire REQ_STALL_O,
	output reg RESP_VALID_O,
	output reg [31:0] PADDR_O,
	output reg [2:0] CACHE_ATTR_O,
	output reg [1:0] TARGET_O,
	output reg WRITE_O,
	output reg ADDR_ERR_O,
	output reg DEBUG_ADDR_EXC_O,
	output reg REDIRECT_VALID_O,
	output reg [31:0] REDIRECT_PC_O,
	output wire EXCEPTION_LEVEL_BIT_O,
	output wire ERROR_LEVEL_BIT_O,
	output wire DEBUG_MODE_FLAG_O,
	output wire [1:0] MODE_O,
	output wire INTERNAL_CACHED_O
);
	//--------------------------------------------------
	// mode state
	//--------------------------------------------------
	wire [1:0] mode;
	wire exception_level_bit;
	wire error_level_bit;
	wire dm;
	pst_mode_ctrl u_mode
	(
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.user_privilege_bit_i(USER_PRIVILEGE_BIT_I),
		.exc_i(EXC_I),
		.err_exc_i(ERR_EXC_I),
		.exception_return_op_i(EXCEPTION_RETURN_OP_I),
		.nmi_i(NMI_I),
		.soft_reset_i(SOFT_RESET_I),
		.debug_exc_i(DEBUG_EXC_I),
		.debug_return_i(DEBUG_RETURN_I),
		.exception_level_bit_o(exception_level_bit),
		.error_level_bit_o(error_level_bit),
		.debug_mode_flag_o(dm),
		.mode_o(mode)
	);
	assign EXCEPTION_LEVEL_BIT_O = exception_level_bit;
	assign ERROR_LEVEL_BIT_O = error_level_bit;
	assign DEBUG_MODE_FLAG_O = dm;
	assign MODE_O = mode;
	// no caches inside; attribute only travels outward
	assign INTERNAL_CACHED_O = 1'b0;

	//--------------------------------------------------
	// segment decode
	//--------------------------------------------------
	wire [2:0] seg;
	wire [31:0] seg_paddr;
	wire [2:0] seg_attr;
	pst_seg_decode u_seg
	(
		.vaddr_i(REQ_VADDR_I),
		.config_i(CONFIG_I),
		.error_level_bit_i(error_level_bit),
		.seg_o(seg),
		.paddr_o(seg_paddr),
		.cache_attr_o(seg_attr)
	);

	//--------------------------------------------------
	// debug overlay steering
	//--------------------------------------------------
	wire in_ovl_probe;
	wire in_ovl_reg;
	wire ovl_on;
	wire to_normal;
	wire probe_wait;
	assign ovl_on = (mode == `PST_MODE_DEBUG) && OVERLAY_ENABLE_I;
	assign in_ovl_probe = ovl_on && (REQ_VADDR_I[31:20] == `PST_OVL_HI);
	assign in_ovl_reg = ovl_on && (REQ_VADDR_I[31:20] == `PST_OVL_REG);
	assign to_normal = !REQ_FETCH_I && LOAD_STORE_NORMAL_MEMORY_BIT_I;
	// reference hangs until probe answers, present bit or not
	assign probe_wait = REQ_VALID_I && in_ovl_probe && !to_normal && !PROBE_ACK_I;
	assign REQ_STALL_O = probe_wait;

	//--------------------------------------------------
	// response register
	//--------------------------------------------------
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			RESP_VALID_O <= 1'b0;
			PADDR_O <= 32'h00000000;
			CACHE_ATTR_O <= 3'h0;
			TARGET_O <= `PST_TGT_MEM;
			WRITE_O <= 1'b0;
			ADDR_ERR_O <= 1'b0;
			DEBUG_ADDR_EXC_O <= 1'b0;
		end
		else
		begin
			RESP_VALID_O <= 1'b0;
			ADDR_ERR_O <= 1'b0;
			DEBUG_ADDR_EXC_O <= 1'b0;
			WRITE_O <= 1'b0;
			if (REQ_VALID_I && !probe_wait)
			begin
				PADDR_O <= seg_paddr;
				CACHE_ATTR_O <= seg_attr;
				TARGET_O <= `PST_TGT_MEM;
				WRITE_O <= REQ_WRITE_I;
				RESP_VALID_O <= 1'b1;
				if (mode == `PST_MODE_USER && REQ_VADDR_I[31])
				begin
					ADDR_ERR_O <= 1'b1;
					RESP_VALID_O <= 1'b0;
					WRITE_O <= 1'b0;
				end
				else if (in_ovl_probe && !to_normal)
				begin
					PADDR_O <= {12'h000, REQ_VADDR_I[19:0]};
					CACHE_ATTR_O <= `PST_UNCACHED;
					TARGET_O <= `PST_TGT_PROBE;
				end
				else if (in_ovl_reg && !to_normal)
				begin
					PADDR_O <= {12'h000, REQ_VADDR_I[19:0]};
					CACHE_ATTR_O <= `PST_UNCACHED;
					TARGET_O <= `PST_TGT_DREG;
					if (REQ_SIZE_I != `PST_SIZE_WORD)
					begin
						// only word transfers reach the registers
						RESP_VALID_O <= 1'b0;
						WRITE_O <= 1'b0;
					end
					else if (REQ_WRITE_I && !DREG_IMPL_I)
						WRITE_O <= 1'b0;
				end
			end
			// debug mode turns the kernel fault into a debug exception
			if (REQ_VALID_I && mode == `PST_MODE_DEBUG && in_ovl_reg && !to_normal
				&& REQ_SIZE_I != `PST_SIZE_WORD)
				DEBUG_ADDR_EXC_O <= 1'b1;
		end
	end

	//--------------------------------------------------
	// exception return redirect
	//--------------------------------------------------
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			REDIRECT_VALID_O <= 1'b0;
			REDIRECT_PC_O <= 32'h00000000;
		end
		else
		begin
			REDIRECT_VALID_O <= EXCEPTION_RETURN_OP_I;
			if (EXCEPTION_RETURN_OP_I)
				REDIRECT_PC_O <= EXCEPTION_RETURN_PC_I;
		end
	end
endmodule
`default_nettype wire

// *** core/pst_map.vh ***
// constants for the privilege mode segment translator
`ifndef PST_MAP_VH
`define PST_MAP_VH
`define PST_MODE_USER 2'h0
`define PST_MODE_KERNEL 2'h1
`define PST_MODE_DEBUG 2'h2
`define PST_SEG_USER 3'h0
`define PST_SEG_KA 3'h1
`define PST_SEG_KB 3'h2
`define PST_SEG_KC 3'h3
`define PST_SEG_KD 3'h4
`define PST_TGT_MEM 2'h0
`define PST_TGT_PROBE 2'h1
`define PST_TGT_DREG 2'h2
`define PST_KA_BASE 32'h80000000
`define PST_KB_BASE 32'hA0000000
`define PST_OVL_HI 12'hFF2
`define PST_OVL_REG 12'hFF3
`define PST_KH_MSB 30
`define PST_KH_LSB 28
`define PST_KU_MSB 27
`define PST_KU_LSB 25
`define PST_K0_MSB 2
`define PST_K0_LSB 0
`define PST_UNCACHED 3'h2
`define PST_SIZE_WORD 2'h2
`endif

// *** core/pst_mode_ctrl.v ***
// status bit holder and mode decode
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.vh"
module pst_mode_ctrl
(
	input wire clk_i,
	input wire rst_i,
	input wire user_privilege_bit_i,
	input wire exc_i,
	input wire err_exc_i,
	input wire exception_return_op_i,
	input wire nmi_i,
	input wire soft_reset_i,
	input wire debug_exc_i,
	input wire debug_return_i,
	output reg exception_level_bit_o,
	output reg error_level_bit_o,
	output reg debug_mode_flag_o,
	output reg [1:0] mode_o
);
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			exception_level_bit_o <= 1'b0;
			error_level_bit_o <= 1'b1;
			debug_mode_flag_o <= 1'b0;
		end
		else
		begin
			// error conditions set over a return
			if (soft_reset_i || nmi_i || err_exc_i)
				error_level_bit_o <= 1'b1;
			else if (exception_return_op_i)
				error_level_bit_o <= 1'b0;
			if (exc_i)
				exception_level_bit_o <= 1'b1;
			else if (exception_return_op_i && !error_level_bit_o)
				exception_level_bit_o <= 1'b0;
			if (debug_exc_i)
				debug_mode_flag_o <= 1'b1;
			else if (debug_return_i)
				debug_mode_flag_o <= 1'b0;
		end
	end
	always @*
	begin
		if (debug_mode_flag_o)
			mode_o = `PST_MODE_DEBUG;
		else if (user_privilege_bit_i && !exception_level_bit_o && !error_level_bit_o)
			mode_o = `PST_MODE_USER;
		else
			mode_o = `PST_MODE_KERNEL;
	end
endmodule
`default_nettype wire

// *** core/pst_seg_decode.v ***
// combinational segment decode and translation
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.vh"
module pst_seg_decode
(
	input wire [31:0] vaddr_i,
	input wire [31:0] config_i,
	input wire error_level_bit_i,
	output reg [2:0] seg_o,
	output reg [31:0] paddr_o,
	output reg [2:0] cache_attr_o
);
	always @*
	begin
		seg_o = `PST_SEG_USER;
		paddr_o = vaddr_i;
		cache_attr_o = config_i[`PST_KU_MSB:`PST_KU_LSB];
		if (!vaddr_i[31])
		begin
			if (error_level_bit_i)
				cache_attr_o = `PST_UNCACHED;
		end
		else
		begin
			case (vaddr_i[30:29])
			2'h0:
			begin
				seg_o = `PST_SEG_KA;
				paddr_o = vaddr_i - `PST_KA_BASE;
				cache_attr_o = config_i[`PST_K0_MSB:`PST_K0_LSB];
			end
			2'h1:
			begin
				seg_o = `PST_SEG_KB;
				paddr_o = vaddr_i - `PST_KB_BASE;
				cache_attr_o = `PST_UNCACHED;
			end
			2'h2:
			begin
				seg_o = `PST_SEG_KC;
				cache_attr_o = config_i[`PST_KH_MSB:`PST_KH_LSB];
			end
			default:
			begin
				seg_o = `PST_SEG_KD;
				cache_attr_o = config_i[`PST_KH_MSB:`PST_KH_LSB];
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** tb/pst_asserts.sv ***
// checker for the segment translator ports
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.vh"
module pst_asserts
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic USER_PRIVILEGE_BIT_I,
	input wire logic EXC_I,
	input wire logic ERR_EXC_I,
	input wire logic EXCEPTION_RETURN_OP_I,
	input wire logic [31:0] EXCEPTION_RETURN_PC_I,
	input wire logic NMI_I,
	input wire logic SOFT_RESET_I,
	input wire logic [31:0] CONFIG_I,
	input wire logic LOAD_STORE_NORMAL_MEMORY_BIT_I,
	input wire logic OVERLAY_ENABLE_I,
	input wire logic REQ_VALID_I,
	input wire logic REQ_FETCH_I,
	input wire logic [31:0] REQ_VADDR_I,
	input wire logic PROBE_ACK_I,
	input wire logic REQ_STALL_O,
	input wire logic [31:0] PADDR_O,
	input wire logic [2:0] CACHE_ATTR_O,
	input wire logic ADDR_ERR_O,
	input wire logic REDIRECT_VALID_O,
	input wire logic [31:0] REDIRECT_PC_O,
	input wire logic EXCEPTION_LEVEL_BIT_O,
	input wire logic ERROR_LEVEL_BIT_O,
	input wire logic DEBUG_MODE_FLAG_O,
	input wire logic [1:0] MODE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	wire tk = REQ_VALID_I & ~REQ_STALL_O;
	logic [31:0] va_reg;
	logic [31:0] cfg_reg;
	// request context kept one cycle for the answer checks
	always @(posedge CLK_I)
	begin
		va_reg <= REQ_VADDR_I;
		cfg_reg <= CONFIG_I;
	end
	a_mode_decode:
		assert property (MODE_O == (DEBUG_MODE_FLAG_O ? 2'h2 : (USER_PRIVILEGE_BIT_I &
			~EXCEPTION_LEVEL_BIT_O & ~ERROR_LEVEL_BIT_O) ? 2'h0 : 2'h1)) else $error("mode wrong");
	a_user_fault:
		assert property (tk & MODE_O == 2'h0 & REQ_VADDR_I[31] |=> ADDR_ERR_O) else $error("no fault");
	a_seg_a:
		assert property (tk & MODE_O != 2'h0 & REQ_VADDR_I[31:29] == 3'h4 |=> PADDR_O ==
			va_reg - `PST_KA_BASE && CACHE_ATTR_O == cfg_reg[2:0]) else $error("region a wrong");
	a_seg_b:
		assert property (tk & MODE_O != 2'h0 & REQ_VADDR_I[31:29] == 3'h5 |=> PADDR_O ==
			va_reg - `PST_KB_BASE && CACHE_ATTR_O == `PST_UNCACHED) else $error("region b wrong");
	a_seg_cd:
		assert property (tk & MODE_O == 2'h1 & REQ_VADDR_I[31:30] == 2'h3 |=> PADDR_O ==
			va_reg && CACHE_ATTR_O == cfg_reg[30:28]) else $error("region c or d wrong");
	a_low_region:
		assert property (tk & ~REQ_VADDR_I[31] |=> PADDR_O == va_reg && CACHE_ATTR_O ==
			($past(ERROR_LEVEL_BIT_O) ? `PST_UNCACHED : cfg_reg[27:25])) else $error("low wrong");
	a_exc_set:
		assert property (EXC_I |=> EXCEPTION_LEVEL_BIT_O) else $error("exception level not set");
	a_err_set:
		assert property (NMI_I | SOFT_RESET_I |=> ERROR_LEVEL_BIT_O) else $error("error level not set");
	a_ret_clear:
		assert property (EXCEPTION_RETURN_OP_I & ~EXC_I & ~ERR_EXC_I & ~NMI_I & ~SOFT_RESET_I
			|=> REDIRECT_VALID_O && REDIRECT_PC_O == $past(EXCEPTION_RETURN_PC_I) &&
			!ERROR_LEVEL_BIT_O && EXCEPTION_LEVEL_BIT_O == ($past(ERROR_LEVEL_BIT_O) &
			$past(EXCEPTION_LEVEL_BIT_O))) else $error("return wrong");
	a_probe_stall:
		assert property (REQ_VALID_I & DEBUG_MODE_FLAG_O & OVERLAY_ENABLE_I & ~PROBE_ACK_I &
			REQ_VADDR_I[31:20] == `PST_OVL_HI & (REQ_FETCH_I | ~LOAD_STORE_NORMAL_MEMORY_BIT_I)
			|-> REQ_STALL_O) else $error("probe reference not held");
	c_stall: cover property (REQ_STALL_O ##1 ~REQ_STALL_O);
	c_fault: cover property (ADDR_ERR_O);
	c_ret: cover property (REDIRECT_VALID_O);
endmodule
bind pst_translator pst_asserts pst_asserts_i (.*);
`default_nettype wire

// *** tb/pst_probe_model.sv ***
// probe side model answering held probe window references
`timescale 1ns/1ps
`default_nettype none
module pst_probe_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic [3:0] delay_i,
	output logic ack_o
);
	logic [3:0] cnt_reg;
	// answers even with present bit clear, the race makes that case real
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			cnt_reg <= 4'h0;
		end
		else if (ack_o | ~stall_i)
		begin
			ack_o <= 1'b0;
			cnt_reg <= 4'h0;
		end
		else
		begin
			ack_o <= cnt_reg == delay_i;
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the segment translator
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.vh"
module testbench;
	typedef struct {logic [2:0] k; logic [1:0] tg; logic [34:0] ap; logic w;} pst_exp_t;
	logic CLK_I = 1'b0, RST_I = 1'b1, USER_PRIVILEGE_BIT_I = 1'b0, PROBE_PRESENT_BIT_I = 1'b1;
	logic LOAD_STORE_NORMAL_MEMORY_BIT_I = 1'b0, OVERLAY_ENABLE_I = 1'b0, DREG_IMPL_I = 1'b0;
	logic REQ_VALID_I = 1'b0, REQ_FETCH_I = 1'b0, REQ_WRITE_I = 1'b0, erl_x = 1'b1;
	logic [1:0] REQ_SIZE_I = 2'h2;
	logic [6:0] ev = 7'h00;
	logic [3:0] dly = 4'h3;
	logic [31:0] EXCEPTION_RETURN_PC_I = 32'h0, CONFIG_I = 32'h0, REQ_VADDR_I = 32'h0, va;
	wire EXC_I, ERR_EXC_I, EXCEPTION_RETURN_OP_I, NMI_I, SOFT_RESET_I, DEBUG_EXC_I;
	wire DEBUG_RETURN_I, PROBE_ACK_I, REQ_STALL_O, RESP_VALID_O, WRITE_O, ADDR_ERR_O;
	wire DEBUG_ADDR_EXC_O, REDIRECT_VALID_O, EXCEPTION_LEVEL_BIT_O, ERROR_LEVEL_BIT_O;
	wire DEBUG_MODE_FLAG_O, INTERNAL_CACHED_O;
	wire [31:0] PADDR_O, REDIRECT_PC_O;
	wire [2:0] CACHE_ATTR_O;
	wire [1:0] TARGET_O, MODE_O;
	int mismatches = 0, n_checks = 0, cyc = 0;
	pst_exp_t q[$];
	pst_exp_t e;
	assign {DEBUG_RETURN_I, DEBUG_EXC_I, SOFT_RESET_I, NMI_I, EXCEPTION_RETURN_OP_I, ERR_EXC_I,
		EXC_I} = ev;
	pst_translator pst_translator_i (.*);
	pst_probe_model pst_probe_model_i (.clk_i(CLK_I), .rst_i(RST_I), .stall_i(REQ_STALL_O),
		.delay_i(dly), .ack_o(PROBE_ACK_I));
	initial forever #20 CLK_I = ~CLK_I;
	task complete_run;
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [34:0] x, input logic [34:0] g);
		n_checks++;
		if (g !== x)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	function automatic [34:0] mem(input [31:0] a);
		case (a[31:29])
		3'h4: mem = {CONFIG_I[2:0], a - `PST_KA_BASE};
		3'h5: mem = {`PST_UNCACHED, a - `PST_KB_BASE};
		3'h6, 3'h7: mem = {CONFIG_I[30:28], a};
		default: mem = {erl_x ? `PST_UNCACHED : CONFIG_I[27:25], a};
		endcase
	endfunction
	// m is {overlay, normal memory, present, implemented}, changed only with a new request
	task req(input [31:0] a, input f, w, input [1:0] s, input [3:0] m, input [2:0] k,
		input [1:0] t, input [34:0] ap);
		@(negedge CLK_I);
		REQ_VALID_I = 1'b1;
		REQ_VADDR_I = a;
		REQ_FETCH_I = f;
		REQ_WRITE_I = w;
		REQ_SIZE_I = s;
		{OVERLAY_ENABLE_I, LOAD_STORE_NORMAL_MEMORY_BIT_I, PROBE_PRESENT_BIT_I, DREG_IMPL_I} = m;
		#1;
		while (REQ_STALL_O !== 1'b0)
		begin
			@(negedge CLK_I);
			#1;
		end
		q.push_back('{k, t, ap, w & (t != 2'h2 | DREG_IMPL_I)});
	endtask
	task pulse(input [6:0] m);
		@(negedge CLK_I);
		REQ_VALID_I = 1'b0;
		ev = m;
		@(negedge CLK_I);
		ev = 7'h00;
		#1;
		if (m[2])
			chk("redirect", {2'h1, EXCEPTION_RETURN_PC_I}, {REDIRECT_VALID_O, REDIRECT_PC_O});
	endtask
	task sweep;
		for (int i = 0; i < 16; i++)
		begin
			va = $urandom;
			va[31:29] = i[2:0];
			if (MODE_O === 2'h0 && va[31])
				req(va, 1'b0, 1'b0, 2'h2, 4'h0, 3'h2, 2'h0, 35'h0);
			else
				req(va, i[3], i[0] & ~i[3], 2'h2, 4'h0, 3'h1, 2'h0, mem(va));
		end
	endtask
	// ----------------------------------------
	// answer watcher
	// ----------------------------------------
	always @(negedge CLK_I)
		if ({DEBUG_ADDR_EXC_O, ADDR_ERR_O, RESP_VALID_O} !== 3'h0 && !RST_I)
		begin
			e = q.size() ? q.pop_front() : '{3'h0, 2'h0, 35'h0, 1'b0};
			chk("kind", e.k, {DEBUG_ADDR_EXC_O, ADDR_ERR_O, RESP_VALID_O});
			if (e.k == 3'h1)
			begin
				chk("paddr", e.ap[31:0], PADDR_O);
				if (e.tg != 2'h2)
					chk("attr", e.ap[34:32], CACHE_ATTR_O);
				chk("target", e.tg, TARGET_O);
				chk("write", e.w, WRITE_O);
			end
		end
	always @(posedge CLK_I)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			complete_run();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(62));
		CONFIG_I = $urandom;
		EXCEPTION_RETURN_PC_I = $urandom;
		repeat (6) @(posedge CLK_I);
		@(negedge CLK_I);
		RST_I = 1'b0;
		#1;
		chk("mode", 2'h1, MODE_O);
		chk("erl", 1'b1, ERROR_LEVEL_BIT_O);
		chk("icache", 1'b0, INTERNAL_CACHED_O);
		sweep();
		pulse(7'h04);
		erl_x = 1'b0;
		sweep();
		pulse(7'h00);
		USER_PRIVILEGE_BIT_I = 1'b1;
		#1;
		chk("mode", 2'h0, MODE_O);
		sweep();
		pulse(7'h01);
		chk("mode", 2'h1, MODE_O);
		pulse(7'h08);
		pulse(7'h04);
		chk("exl", 1'b1, EXCEPTION_LEVEL_BIT_O);
		pulse(7'h04);
		chk("mode", 2'h0, MODE_O);
		pulse(7'h10);
		pulse(7'h02);
		chk("erl", 1'b1, ERROR_LEVEL_BIT_O);
		pulse(7'h24);
		chk("mode", 2'h2, MODE_O);
		chk("dm", 1'b1, DEBUG_MODE_FLAG_O);
		va = 32'hFF200000 | ($urandom & 32'hFFFFC);
		req(va, 1, 0, 2'h2, 4'hA, 3'h1, 2'h1, {`PST_UNCACHED, 12'h0, va[19:0]});
		dly = 4'h0;
		req(va, 0, 1, 2'h2, 4'h8, 3'h1, 2'h1, {`PST_UNCACHED, 12'h0, va[19:0]});
		req(va, 0, 0, 2'h2, 4'hE, 3'h1, 2'h0, {CONFIG_I[30:28], va});
		req(va, 1, 0, 2'h2, 4'h2, 3'h1, 2'h0, {CONFIG_I[30:28], va});
		va = 32'hFF300000 | ($urandom & 32'hFFFFC);
		req(va, 0, 0, 2'h2, 4'hC, 3'h1, 2'h0, {CONFIG_I[30:28], va});
		req(va, 0, 1, 2'h2, 4'h9, 3'h1, 2'h2, {3'h0, 12'h0, va[19:0]});
		req(va, 0, 1, 2'h2, 4'h8, 3'h1, 2'h2, {3'h0, 12'h0, va[19:0]});
		req(va, 1, 0, 2'h2, 4'hC, 3'h1, 2'h2, {3'h0, 12'h0, va[19:0]});
		req(va, 0, 0, 2'h0, 4'h8, 3'h4, 2'h2, 35'h0);
		pulse(7'h40);
		chk("mode", 2'h0, MODE_O);
		chk("dm", 1'b0, DEBUG_MODE_FLAG_O);
		repeat (3) @(negedge CLK_I);
		chk("pending", 35'h0, q.size());
		complete_run();
	end
endmodule
`default_nettype wire
